//--- rtl/gmd_decode.sv
// multiline command decoder with interrupt status and handshake stall
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "gmd_cfg.svh"

// Behaviour
// - flags set on the accept strobe; interrupt pin low only when unmasked
// - addressed-class interrupts need listener addressed, except take-control
// - handshake stall only when the causing flag is unmasked
// - primary listen/talk address matching own gives my-address, stall, address-change
// - secondary bytes X11SSSSS after our own primary listen/talk address are handed to the host
// - parallel poll configure raises unrecognized-command with stall
// - after pass-secondary command, poll enable/disable bytes raise pass-through
// - parallel poll unconfigure raises unrecognized-command, stall if unmasked
// - take-control raises unrecognized-command with stall only while talker addressed
// - remote/local flag on listen address or go-to-local state change
// - data lines are inverted: low level means logical one
module gmd_decode (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output      logic [31:0]           hrdata,
    output      logic                  hreadyout,
    output      logic                  hresp,
    // bus pins and acceptor side
    input  wire logic [7:0]            dio_n,
    input  wire logic                  atn_n,
    input  wire logic                  accept_data_substate_one,
    input  wire gmd_pkg::gmd_fn_state_t fn_state,
    // outputs
    output      logic                  int_n,
    output      logic                  dac_hold
);
    // ==========================================================
    // pin synchronisers
    // bits synced one by one; safe only because the source holds them before the strobe
    logic [7:0] dio_n_s;
    logic       atn_n_s;

    gmd_sync #(.WIDTH(8), .RST(8'hff)) u_sync_dio (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (dio_n),
        .dout    (dio_n_s)
    );

    gmd_sync #(.WIDTH(1), .RST(1'b1)) u_sync_atn (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (atn_n),
        .dout    (atn_n_s)
    );

    // ==========================================================
    // registers
    gmd_pkg::gmd_ahb_req_t req_q, req_d;
    logic                  req_v_q, req_v_d;
    logic [31:0]           hrdata_q, hrdata_d;
    logic [6:0]            mask_q, mask_d;
    logic [4:0]            addr_q, addr_d;
    logic                  pts_q, pts_d;
    logic                  prim_mine_q, prim_mine_d;
    logic [7:0]            pass_q, pass_d;
    gmd_pkg::gmd_hold_t    hold_q, hold_d;
    logic                  int_n_q, int_n_d;
    logic [6:0]            status;
    logic [6:0]            set_ev;
    logic [6:0]            clr_ev;
    logic                  aux_wr;
    logic [4:0]            aux_code;
    logic                  aux_cs;

    // ==========================================================
    // command decode
    // own address 31 never matches: that code means unlisten or untalk
    logic [7:0] cmd;
    logic [6:0] c7;
    logic       take;
    logic       addr_hit;
    logic       is_secondary;

    always_comb begin
        cmd          = ~dio_n_s;
        c7           = cmd[6:0];
        take         = accept_data_substate_one & ~atn_n_s;
        addr_hit     = (c7[4:0] == addr_q);
        is_secondary = (c7[6:5] == 2'b11);
        set_ev       = 7'h00;
        if (take) begin
            case (c7[6:5])
                2'b01: begin
                    if (c7[4:0] == `GMD_ADDR_NONE) begin
                        set_ev[`GMD_BIT_ADDRCHG] = fn_state.lads;
                    end else if (addr_hit) begin
                        set_ev[`GMD_BIT_MYADDR]  = 1'b1;
                        set_ev[`GMD_BIT_ADDRCHG] = 1'b1;
                        set_ev[`GMD_BIT_RLC]     = fn_state.ren & ~fn_state.remote;
                    end
                end
                2'b10: begin
                    if (c7[4:0] == `GMD_ADDR_NONE) begin
                        set_ev = 7'h00;
                    end else if (addr_hit) begin
                        set_ev[`GMD_BIT_MYADDR]  = 1'b1;
                        set_ev[`GMD_BIT_ADDRCHG] = 1'b1;
                    end else begin
                        set_ev[`GMD_BIT_ADDRCHG] = fn_state.tads;
                    end
                end
                2'b11: begin
                    // secondary bytes go to the host for interpretation
                    set_ev[`GMD_BIT_PASSTHRU] = prim_mine_q | pts_q;
                end
                default: begin
                    if (c7[4]) begin
                        case (c7)
                            `GMD_CMD_DCL: set_ev[`GMD_BIT_DEVCLR] = 1'b1;
                            `GMD_CMD_PPU: set_ev[`GMD_BIT_UNREC]  = 1'b1;
                            default:      set_ev = 7'h00;
                        endcase
                    end else begin
                        case (c7)
                            `GMD_CMD_GTL: begin
                                set_ev[`GMD_BIT_RLC] = fn_state.lads & fn_state.remote;
                            end
                            `GMD_CMD_SDC: set_ev[`GMD_BIT_DEVCLR]  = fn_state.lads;
                            `GMD_CMD_PPC: set_ev[`GMD_BIT_UNREC]   = fn_state.lads;
                            `GMD_CMD_GET: set_ev[`GMD_BIT_TRIGGER] = fn_state.lads;
                            `GMD_CMD_TCT: set_ev[`GMD_BIT_UNREC]   = fn_state.tads;
                            default:      set_ev = 7'h00;
                        endcase
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // sticky status bits
    // one cell per flag keeps set and clear behaviour identical
    genvar gi;
    generate
        for (gi = 0; gi < `GMD_NFLAGS; gi = gi + 1) begin : g_flag
            gmd_sticky u_flag (
                .clk     (clk),
                .sys_rst (sys_rst),
                .set     (set_ev[gi]),
                .clr     (clr_ev[gi]),
                .q       (status[gi])
            );
        end
    endgenerate

    // ==========================================================
    // ahb-lite slave, zero wait states
    // read data latched in the address phase, so the data phase needs no mux
    logic [31:0] rd_mux;
    logic        wr_dp;

    always_comb begin
        req_v_d    = hsel & hready & htrans[1];
        req_d      = req_q;
        if (req_v_d) begin
            req_d.write = hwrite;
            req_d.addr  = haddr[7:0];
        end
        case ({haddr[7:2], 2'b00})
            `GMD_OFF_STATUS: rd_mux = {25'h0, status};
            `GMD_OFF_MASK:   rd_mux = {25'h0, mask_q};
            `GMD_OFF_CTRL:   rd_mux = {27'h0, addr_q};
            `GMD_OFF_PASS:   rd_mux = {24'h0, pass_q};
            `GMD_OFF_STATE:  rd_mux = {29'h0, pts_q, prim_mine_q, dac_hold};
            default:         rd_mux = 32'h0;
        endcase
        hrdata_d = (req_v_d & ~hwrite) ? rd_mux : hrdata_q;
        wr_dp    = req_v_q & req_q.write;
        clr_ev   = (wr_dp && req_q.addr == `GMD_OFF_STATUS) ? hwdata[6:0] : 7'h00;
        mask_d   = (wr_dp && req_q.addr == `GMD_OFF_MASK) ? hwdata[6:0] : mask_q;
        addr_d   = (wr_dp && req_q.addr == `GMD_OFF_CTRL)
                 ? hwdata[`GMD_CTRL_ADDR_MSB:`GMD_CTRL_ADDR_LSB] : addr_q;
        aux_wr   = wr_dp && (req_q.addr == `GMD_OFF_AUX);
        aux_code = hwdata[`GMD_AUX_CODE_MSB:`GMD_AUX_CODE_LSB];
        aux_cs   = hwdata[`GMD_AUX_CS];
    end

    // ==========================================================
    // pass-through byte, addressing memory, secondary pass mode
    always_comb begin
        pass_d      = take ? cmd : pass_q;
        prim_mine_d = prim_mine_q;
        pts_d       = pts_q;
        if (take && (c7[6:5] == 2'b01 || c7[6:5] == 2'b10)) begin
            // remembers whether the last primary address was ours
            prim_mine_d = addr_hit && (c7[4:0] != `GMD_ADDR_NONE);
        end
        // mode survives the configure byte so the host can still turn it on
        if (take && !is_secondary && c7 != `GMD_CMD_PPC) begin
            pts_d = 1'b0;
        end
        if (aux_wr && aux_code == `GMD_AUX_PASS_SEC) begin
            pts_d = aux_cs;
        end
    end

    // ==========================================================
    // handshake stall
    always_comb begin
        hold_d = hold_q;
        case (hold_q)
            gmd_pkg::GMD_RUN: begin
                if (|(set_ev & mask_q & `GMD_STALL_SET)) begin
                    hold_d = gmd_pkg::GMD_HOLD;
                end
            end
            gmd_pkg::GMD_HOLD: begin
                // further events during a stall only land in status
                // released only by the host command with set bit zero
                if (aux_wr && aux_code == `GMD_AUX_RELEASE && !aux_cs) begin
                    hold_d = gmd_pkg::GMD_RUN;
                end
            end
            default: hold_d = gmd_pkg::GMD_RUN;
        endcase
        int_n_d = ~|(status & mask_q);
    end

    // ==========================================================
    // state registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_q       <= '0;
            req_v_q     <= 1'b0;
            hrdata_q    <= 32'h0;
            mask_q      <= `GMD_RST_MASK;
            addr_q      <= `GMD_RST_ADDR;
            pts_q       <= 1'b0;
            prim_mine_q <= 1'b0;
            pass_q      <= 8'h00;
            hold_q      <= gmd_pkg::GMD_RUN;
            int_n_q     <= 1'b1;
        end else begin
            req_q       <= req_d;
            req_v_q     <= req_v_d;
            hrdata_q    <= hrdata_d;
            mask_q      <= mask_d;
            addr_q      <= addr_d;
            pts_q       <= pts_d;
            prim_mine_q <= prim_mine_d;
            pass_q      <= pass_d;
            hold_q      <= hold_d;
            int_n_q     <= int_n_d;
        end
    end

    // ==========================================================
    // outputs, all from flops
    logic hready_q, hready_d;
    logic hresp_q, hresp_d;
    logic dac_hold_q, dac_hold_d;

    // stall copy loads from the same next state, so it matches the state flop
    always_comb begin
        hready_d   = 1'b1;
        hresp_d    = 1'b0;
        dac_hold_d = (hold_d == gmd_pkg::GMD_HOLD);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hready_q   <= 1'b1;
            hresp_q    <= 1'b0;
            dac_hold_q <= 1'b0;
        end else begin
            hready_q   <= hready_d;
            hresp_q    <= hresp_d;
            dac_hold_q <= dac_hold_d;
        end
    end

    always_comb begin
        hrdata    = hrdata_q;
        hreadyout = hready_q;
        hresp     = hresp_q;
        int_n     = int_n_q;
        dac_hold  = dac_hold_q;
    end
endmodule : gmd_decode

//--- rtl/gmd_cfg.svh
// offsets, field positions, reset values and codes for the command decoder
`ifndef GMD_CFG_SVH
`define GMD_CFG_SVH

// ==========================================================
// register byte offsets
`define GMD_OFF_STATUS      8'h00
`define GMD_OFF_MASK        8'h04
`define GMD_OFF_CTRL        8'h08
`define GMD_OFF_AUX         8'h0c
`define GMD_OFF_PASS        8'h10
`define GMD_OFF_STATE       8'h14

// ==========================================================
// status and mask bit positions
`define GMD_NFLAGS          7
`define GMD_BIT_DEVCLR      0
`define GMD_BIT_TRIGGER     1
`define GMD_BIT_RLC         2
`define GMD_BIT_UNREC       3
`define GMD_BIT_PASSTHRU    4
`define GMD_BIT_MYADDR      5
`define GMD_BIT_ADDRCHG     6
// flags whose unmasked setting stalls the handshake
`define GMD_STALL_SET       7'h3b

// ==========================================================
// control and auxiliary fields
`define GMD_CTRL_ADDR_LSB   0
`define GMD_CTRL_ADDR_MSB   4
`define GMD_AUX_CODE_LSB    0
`define GMD_AUX_CODE_MSB    4
`define GMD_AUX_CS          7
`define GMD_AUX_RELEASE     5'h00
`define GMD_AUX_PASS_SEC    5'h1e

// ==========================================================
// reset values
`define GMD_RST_MASK        7'h00
`define GMD_RST_ADDR        5'h00

// ==========================================================
// command byte codes, logical polarity, bit 8 ignored
`define GMD_CMD_GTL         7'h01
`define GMD_CMD_SDC         7'h04
`define GMD_CMD_PPC         7'h05
`define GMD_CMD_GET         7'h08
`define GMD_CMD_TCT         7'h09
`define GMD_CMD_DCL         7'h14
`define GMD_CMD_PPU         7'h15
`define GMD_ADDR_NONE       5'h1f

`endif

//--- rtl/gmd_pkg.sv
// types shared by the command decoder files
package gmd_pkg;

    // ==========================================================
    // handshake stall state, gray order
    typedef enum logic [1:0] {
        GMD_RUN  = 2'b00,
        GMD_HOLD = 2'b01
    } gmd_hold_t;

    // ==========================================================
    // captured bus address phase
    typedef struct packed {
        logic       write;
        logic [7:0] addr;
    } gmd_ahb_req_t;

    // ==========================================================
    // state of the surrounding interface functions
    typedef struct packed {
        logic lads;
        logic tads;
        logic remote;
        logic ren;
    } gmd_fn_state_t;

endpackage : gmd_pkg

//--- rtl/gmd_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module gmd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST = '0
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] din,
    output      logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    // ==========================================================
    // first stage feeds only the second
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= RST;
            dout   <= RST;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : gmd_sync

//--- rtl/gmd_sticky.sv
// sticky status bit with write-one clear, set wins
`timescale 1ns/1ns
module gmd_sticky (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic set,
    input  wire logic clr,
    output      logic q
);
    logic q_d;

    // ==========================================================
    // set beats clear so no event is lost
    always_comb begin
        q_d = set | (q & ~clr);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= 1'b0;
        end else begin
            q <= q_d;
        end
    end
endmodule : gmd_sticky

//--- verif/gmd_decode_monitor.sv
// port checker for the command decoder
`timescale 1ns/1ns
`include "gmd_cfg.svh"
module gmd_mon (
    input wire logic                   clk,
    input wire logic                   sys_rst,
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic                   hready,
    input wire logic [7:0]             dio_n,
    input wire logic                   atn_n,
    input wire logic                   accept_data_substate_one,
    input wire gmd_pkg::gmd_fn_state_t fn_state,
    input wire logic                   int_n,
    input wire logic                   dac_hold
);
    // ==========================================================
    // helpers
    logic       aux_d;
    logic       aux_q;
    logic       stb;
    logic [6:0] cmd;
    // pins held stable around the strobe, so raw pins match the synced byte
    assign stb   = accept_data_substate_one & ~atn_n;
    assign cmd   = ~dio_n[6:0];
    assign aux_d = hsel & hready & htrans[1] & hwrite & (haddr[7:0] == `GMD_OFF_AUX);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aux_q <= 1'b0;
        end else begin
            aux_q <= aux_d;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_cause; $rose(dac_hold) |-> $past(stb); endproperty
    a_cause: assert property (p_cause) else $error("stall without command");
    property p_hold_int; $rose(dac_hold) |=> !int_n; endproperty
    a_hold_int: assert property (p_hold_int) else $error("stall but no irq");
    property p_release; $fell(dac_hold) |-> $past(aux_q) || $past(aux_q, 2); endproperty
    a_release: assert property (p_release) else $error("stall ended alone");
    property p_univ;
        stb && !dac_hold && (cmd == 7'h11 || cmd == 7'h18 || cmd == 7'h19) |=> !dac_hold;
    endproperty
    a_univ: assert property (p_univ) else $error("universal stalled");
    property p_unl;
        stb && !dac_hold && (cmd == 7'h3f || cmd == `GMD_CMD_GTL) |=> !dac_hold;
    endproperty
    a_unl: assert property (p_unl) else $error("unlisten stalled");
    property p_tct; stb && !dac_hold && cmd == `GMD_CMD_TCT && !fn_state.tads |=> !dac_hold;
    endproperty
    a_tct: assert property (p_tct) else $error("take control stalled");
    property p_acg;
        stb && !dac_hold && !fn_state.lads &&
        (cmd == `GMD_CMD_SDC || cmd == `GMD_CMD_GET || cmd == `GMD_CMD_PPC) |=> !dac_hold;
    endproperty
    a_acg: assert property (p_acg) else $error("addressed cmd stalled");
    property p_atn; accept_data_substate_one && atn_n && !dac_hold |=> !dac_hold; endproperty
    a_atn: assert property (p_atn) else $error("stall without attention");
endmodule : gmd_mon

bind gmd_decode gmd_mon u_mon (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .dio_n(dio_n), .atn_n(atn_n),
    .accept_data_substate_one(accept_data_substate_one), .fn_state(fn_state),
    .int_n(int_n), .dac_hold(dac_hold)
);

//--- verif/gmd_talker.sv
// command byte source standing in for controller and acceptor
`timescale 1ns/1ns
module gmd_talker (
    input  wire logic       clk,
    input  wire logic       dac_hold,
    output      logic [7:0] dio_n,
    output      logic       atn_n,
    output      logic       strobe
);
    int settle = 3;
    initial begin
        dio_n  = 8'hff;
        atn_n  = 1'b1;
        strobe = 1'b0;
    end
    // ==========================================================
    // one byte; never strobes into a pending stall
    task automatic send(input logic [7:0] b, input logic atn_hi);
        while (dac_hold !== 1'b0) @(posedge clk);
        dio_n  <= ~b;
        atn_n  <= atn_hi;
        repeat (settle) @(posedge clk);
        strobe <= 1'b1;
        @(posedge clk);
        strobe <= 1'b0;
        dio_n  <= 8'hff;
        atn_n  <= 1'b1;
    endtask : send
endmodule : gmd_talker

//--- verif/gpib_multiline_command_decode_bench.sv
// self-checking bench for the command decoder
`timescale 1ns/1ns
`include "gmd_cfg.svh"
module gpib_multiline_command_decode_bench;
    logic                   clk;
    logic                   sys_rst;
    logic                   hsel;
    logic [31:0]            haddr;
    logic [1:0]             htrans;
    logic                   hwrite;
    logic [2:0]             hsize;
    logic [31:0]            hwdata;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic                   hresp;
    logic [7:0]             dio_n;
    logic                   atn_n;
    logic                   strobe;
    gmd_pkg::gmd_fn_state_t fn_state;
    logic                   int_n;
    logic                   dac_hold;
    logic [31:0]            r;
    int                     err_total;
    int                     checks_done;

    gmd_decode DUT (
        .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dio_n(dio_n),
        .atn_n(atn_n), .accept_data_substate_one(strobe), .fn_state(fn_state),
        .int_n(int_n), .dac_hold(dac_hold)
    );
    gmd_talker u_tlk (
        .clk(clk), .dac_hold(dac_hold), .dio_n(dio_n), .atn_n(atn_n), .strobe(strobe)
    );

    // ==========================================================
    // shared tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done = checks_done + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer

    // full mask assumed: stall follows the stalling flags
    task automatic step(input logic [7:0] b, input logic ah, input logic [3:0] fn,
                        input logic [6:0] es);
        fn_state <= gmd_pkg::gmd_fn_state_t'(fn);
        u_tlk.send(b, ah);
        repeat (3) @(posedge clk);
        chk("hold", {31'h0, dac_hold}, {31'h0, |(es & `GMD_STALL_SET)});
        chk("int_n", {31'h0, int_n}, {31'h0, ~|es});
        xfer(1'b0, `GMD_OFF_STATUS, 32'h0);
        chk("status", r, {25'h0, es});
        if (!ah) begin
            xfer(1'b0, `GMD_OFF_PASS, 32'h0);
            chk("pass", {25'h0, r[6:0]}, {25'h0, b[6:0]});
        end
        xfer(1'b1, `GMD_OFF_STATUS, 32'h7f);
        xfer(1'b1, `GMD_OFF_AUX, 32'h0);
        repeat (2) @(posedge clk);
        chk("released", {31'h0, dac_hold}, 32'h0);
    endtask : step

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk("int_n rst", {31'h0, int_n}, 32'h1);
        chk("hold rst", {31'h0, dac_hold}, 32'h0);
        chk("hreadyout", {31'h0, hreadyout}, 32'h1);
        xfer(1'b0, `GMD_OFF_MASK, 32'h0);
        chk("mask rst", r, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        chk("unmapped", r, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : t_reset

    // masked flag sets status but neither stalls nor interrupts
    task automatic t_masked();
        u_tlk.send(8'h14, 1'b0);
        repeat (3) @(posedge clk);
        chk("masked hold", {31'h0, dac_hold}, 32'h0);
        chk("masked int", {31'h0, int_n}, 32'h1);
        xfer(1'b0, `GMD_OFF_STATUS, 32'h0);
        chk("masked status", r, 32'h1);
        xfer(1'b1, `GMD_OFF_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk("unmask int", {31'h0, int_n}, 32'h0);
        chk("unmask hold", {31'h0, dac_hold}, 32'h0);
        xfer(1'b1, `GMD_OFF_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk("clear int", {31'h0, int_n}, 32'h1);
        xfer(1'b1, `GMD_OFF_MASK, 32'h7f);
        xfer(1'b1, `GMD_OFF_CTRL, 32'h0a);
    endtask : t_masked

    // fn bits: lads, tads, remote, ren
    task automatic t_cmds();
        step(8'h94, 1'b0, 4'h0, 7'h01);
        step(8'h14, 1'b1, 4'h0, 7'h00);
        step(8'h04, 1'b0, 4'h8, 7'h01);
        step(8'h04, 1'b0, 4'h0, 7'h00);
        step(8'h08, 1'b0, 4'h8, 7'h02);
        step(8'h08, 1'b0, 4'h0, 7'h00);
        step(8'h05, 1'b0, 4'h8, 7'h08);
        step(8'h15, 1'b0, 4'h0, 7'h08);
        step(8'h09, 1'b0, 4'h4, 7'h08);
        step(8'h89, 1'b0, 4'h4, 7'h08);
        step(8'h09, 1'b0, 4'h8, 7'h00);
        step(8'h11, 1'b0, 4'h8, 7'h00);
        step(8'h18, 1'b0, 4'h8, 7'h00);
        step(8'h19, 1'b0, 4'h8, 7'h00);
        step(8'h3f, 1'b0, 4'h8, 7'h40);
        step(8'h01, 1'b0, 4'ha, 7'h04);
        step(8'h4b, 1'b0, 4'h4, 7'h40);
        step(8'h2a, 1'b0, 4'h1, 7'h64);
    endtask : t_cmds

    // slow source; secondaries after own talk address and in pass mode
    task automatic t_sec();
        step(8'h4a, 1'b0, 4'h0, 7'h60);
        step(8'h63, 1'b0, 4'h4, 7'h10);
        step(8'h4b, 1'b0, 4'h4, 7'h40);
        step(8'h63, 1'b0, 4'h4, 7'h00);
        step(8'h05, 1'b0, 4'h8, 7'h08);
        xfer(1'b1, `GMD_OFF_AUX, 32'h9e);
        xfer(1'b0, `GMD_OFF_STATE, 32'h0);
        chk("state", r, 32'h4);
        step(8'h6d, 1'b0, 4'h8, 7'h10);
        step(8'h70, 1'b0, 4'h8, 7'h10);
    endtask : t_sec

    task automatic conclude();
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // clock, watchdog, main sequence
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total = err_total + 1;
        conclude();
    end
    initial begin
        sys_rst     = 1'b1;
        hsel        = 1'b0;
        haddr       = 32'h0;
        htrans      = 2'b00;
        hwrite      = 1'b0;
        hsize       = 3'h2;
        hwdata      = 32'h0;
        fn_state    = '0;
        err_total   = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_masked();
        t_cmds();
        u_tlk.settle = 6;
        t_sec();
        conclude();
    end
endmodule : gpib_multiline_command_decode_bench
